// >>> adc_mode_control_regs.sv
// converter mode, clock-source and channel registers with conversion timing
`timescale 1ns/100ps
module adc_mode_control_regs #(
    parameter int main_div = adc_mode_pkg::main_clock_div
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire adc_mode_pkg::reg_req_s i_req,
    input wire logic i_subclk_x4,
    input wire logic [7:0] i_sar_value,
    output logic [7:0] o_rdata,
    output logic [7:0] o_mode,
    output logic [7:0] o_clksel,
    output logic [2:0] o_channel,
    output logic o_bandgap_on,
    output logic o_sample,
    output logic o_conversion_end_irq,
    output adc_mode_pkg::conv_event_s o_event
);
    // divider register is eight bits wide
    if (main_div < 1 || main_div > 256) begin : g_bad_div
        $error("main_div must lie between 1 and 256");
    end

    logic [7:0] mode_reg;
    logic [7:0] clksel_reg;
    logic [7:0] chan_reg;
    logic [7:0] result_reg;
    logic [7:0] count_reg;
    logic [7:0] div_reg;
    logic active_reg;
    logic first_reg;
    logic sub_meta_reg;
    logic sub_sync_reg;
    logic sub_prev_reg;
    logic tick;
    logic restart;

    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input adc_mode_pkg::reg_req_s r,
                                         input logic [7:0] mask);
        logic [7:0] v;
        v = old_v;
        if (r.bit_op) begin
            v[r.bit_idx] = r.wdata[0];
        end else begin
            v = r.wdata;
        end
        return v & mask;
    endfunction : merge

    function automatic logic [7:0] periods(input logic [2:0] code);
        logic [7:0] p;
        p = adc_mode_pkg::periods_000;
        unique case (code)
            3'h0: p = adc_mode_pkg::periods_000;
            3'h1: p = adc_mode_pkg::periods_001;
            3'h2: p = adc_mode_pkg::periods_010;
            3'h4: p = adc_mode_pkg::periods_100;
            3'h5: p = adc_mode_pkg::periods_101;
            3'h6: p = adc_mode_pkg::periods_110;
            default: p = adc_mode_pkg::periods_000;
        endcase
        return p;
    endfunction : periods

    wire mode_wr = i_req.wr && i_req.addr == adc_mode_pkg::converter_mode_control_addr;
    wire clk_wr = i_req.wr && i_req.addr == adc_mode_pkg::converter_clock_source_select_addr;
    wire chan_wr = i_req.wr && i_req.addr == adc_mode_pkg::input_channel_select_addr;
    wire run = mode_reg[adc_mode_pkg::run_pos];
    wire subclk = clksel_reg[adc_mode_pkg::subclk_pos];
    wire [7:0] mode_new = merge(mode_reg, i_req, adc_mode_pkg::mode_mask);
    // subclock selected: fixed count of x4 edges, time field ignored; otherwise the time field picks the count
    wire [7:0] load_count = subclk ? adc_mode_pkg::periods_100
        : periods(mode_reg[adc_mode_pkg::tsel_lo +: 3]);

    // bit or byte write; bits forced zero
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mode_reg <= adc_mode_pkg::mode_reset;
        end else if (mode_wr) begin
            mode_reg <= mode_new;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            clksel_reg <= adc_mode_pkg::clksel_reset;
        end else if (clk_wr) begin
            clksel_reg <= merge(clksel_reg, i_req, adc_mode_pkg::clksel_mask);
        end
    end

    // channel register; low three bits only
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            chan_reg <= adc_mode_pkg::chan_reset;
        end else if (chan_wr) begin
            chan_reg <= merge(chan_reg, i_req, adc_mode_pkg::chan_mask);
        end
    end

    // x4 subsystem clock arrives from another domain
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sub_meta_reg <= 1'b0;
            sub_sync_reg <= 1'b0;
            sub_prev_reg <= 1'b0;
        end else begin
            sub_meta_reg <= i_subclk_x4;
            sub_sync_reg <= sub_meta_reg;
            sub_prev_reg <= sub_sync_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn || div_reg == 8'(main_div - 1)) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // subclock bit switches the time base, time field ignored
    assign tick = subclk ? (sub_sync_reg && !sub_prev_reg) : (div_reg == 8'(main_div - 1));
    // mode or channel write cancels the running conversion
    assign restart = mode_wr || chan_wr;

    // counter loaded with selected period count
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            count_reg <= 8'h00;
            active_reg <= 1'b0;
        end else if (restart || !run) begin
            count_reg <= load_count;
            active_reg <= 1'b0;
        end else if (!active_reg) begin
            count_reg <= load_count;
            active_reg <= 1'b1;
        end else if (tick) begin
            if (count_reg == 8'h01) begin
                active_reg <= 1'b0;
            end
            count_reg <= count_reg - 8'h01;
        end
    end

    wire finish = active_reg && tick && run && !restart && count_reg == 8'h01;

    // first result after start without band-gap flagged undefined
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            first_reg <= 1'b0;
        end else if (mode_wr && !run && mode_new[adc_mode_pkg::run_pos]) begin
            // band-gap must already be running before the start
            first_reg <= !(mode_reg[adc_mode_pkg::bandgap_pos]
                && mode_new[adc_mode_pkg::bandgap_pos]);
        end else if (finish) begin
            first_reg <= 1'b0;
        end
    end

    // store result and pulse irq each end; mode or channel write wins over completion
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            result_reg <= 8'h00;
            o_conversion_end_irq <= 1'b0;
            o_event <= '0;
        end else begin
            o_conversion_end_irq <= finish;
            o_event.done <= finish;
            o_event.first_undefined <= finish && first_reg;
            if (finish) begin
                result_reg <= i_sar_value;
                o_event.result <= i_sar_value;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_req.rd) begin
            unique case (i_req.addr)
                adc_mode_pkg::converter_mode_control_addr: o_rdata <= mode_reg;
                adc_mode_pkg::converter_clock_source_select_addr: o_rdata <= clksel_reg;
                adc_mode_pkg::input_channel_select_addr: o_rdata <= chan_reg;
                adc_mode_pkg::conversion_result_addr: o_rdata <= result_reg;
                default: o_rdata <= 8'h00;
            endcase
        end
    end

    // run bit; band-gap bit; time field
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_mode <= 8'h00;
            o_clksel <= 8'h00;
            o_channel <= 3'h0;
            o_bandgap_on <= 1'b0;
            o_sample <= 1'b0;
        end else begin
            o_mode <= mode_reg;
            o_clksel <= clksel_reg;
            o_channel <= chan_reg[2:0];
            o_bandgap_on <= mode_reg[adc_mode_pkg::bandgap_pos];
            o_sample <= active_reg && run;
        end
    end
endmodule : adc_mode_control_regs

// >>> adc_mode_pkg.sv
// package: register map, field layout, reset values and timing counts for the converter control
package adc_mode_pkg;
    localparam logic [15:0] converter_mode_control_addr = 16'hff80;
    localparam logic [15:0] converter_clock_source_select_addr = 16'hff81;
    localparam logic [15:0] input_channel_select_addr = 16'hff84;
    localparam logic [15:0] conversion_result_addr = 16'hff85;
    localparam logic [7:0] mode_reset = 8'h00;
    localparam logic [7:0] clksel_reset = 8'h00;
    localparam logic [7:0] chan_reset = 8'h00;
    localparam int run_pos = 7;
    localparam int tsel_lo = 3;
    localparam int bandgap_pos = 0;
    localparam int subclk_pos = 7;
    // writable bits; everything else reads zero
    localparam logic [7:0] mode_mask = 8'hb9;
    localparam logic [7:0] clksel_mask = 8'h80;
    localparam logic [7:0] chan_mask = 8'h07;
    // conversion times in main-clock periods
    localparam logic [7:0] periods_000 = 8'h90;
    localparam logic [7:0] periods_001 = 8'h78;
    localparam logic [7:0] periods_010 = 8'h60;
    localparam logic [7:0] periods_100 = 8'h48;
    localparam logic [7:0] periods_101 = 8'h3c;
    localparam logic [7:0] periods_110 = 8'h30;
    // main clock is divided down from i_clk to a main-clock period
    localparam int main_clock_div = 50;

    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_op;
        logic [2:0] bit_idx;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic [7:0] result;
        logic done;
        logic first_undefined;
    } conv_event_s;
endpackage : adc_mode_pkg

// >>> adc_mode_control_regs_checker.sv
// checker: port-level properties of the converter control registers
`timescale 1ns/100ps
module adc_mode_control_regs_checker (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire adc_mode_pkg::reg_req_s i_req,
    input wire logic [7:0] o_mode,
    input wire logic [7:0] o_clksel,
    input wire logic [2:0] o_channel,
    input wire logic o_bandgap_on,
    input wire logic o_sample,
    input wire logic o_conversion_end_irq,
    input wire adc_mode_pkg::conv_event_s o_event
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic wb;
    assign wb = i_req.wr && !i_req.bit_op;
    property p_rst;
        $rose(i_rstn) |-> o_mode == 8'h00 && o_clksel == 8'h00 && o_channel == 3'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("registers not clear");
    property p_mode;
        wb && i_req.addr == 16'hff80 |-> ##2 o_mode == ($past(i_req.wdata, 2) & 8'hb9);
    endproperty
    a_mode: assert property (p_mode) else $error("mode byte write wrong");
    property p_clk;
        wb && i_req.addr == 16'hff81 |-> ##2 o_clksel == {$past(i_req.wdata[7], 2), 7'h00};
    endproperty
    a_clk: assert property (p_clk) else $error("clock source write wrong");
    property p_chan;
        wb && i_req.addr == 16'hff84 |-> ##2 o_channel == $past(i_req.wdata[2:0], 2);
    endproperty
    a_chan: assert property (p_chan) else $error("channel write wrong");
    property p_bitw;
        i_req.wr && i_req.bit_op && i_req.addr == 16'hff80 && i_req.bit_idx == 3'h0
            |-> ##2 o_bandgap_on == $past(i_req.wdata[0], 2) && o_mode[0] == o_bandgap_on;
    endproperty
    a_bitw: assert property (p_bitw) else $error("band-gap bit write wrong");
    property p_irq;
        o_conversion_end_irq |-> o_event.done && $past(o_sample) ##1 !o_conversion_end_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("end pulse malformed");
    property p_stop;
        $fell(o_mode[7]) |-> ##[0:2] !o_sample;
    endproperty
    a_stop: assert property (p_stop) else $error("conversion runs with run bit clear");
    property p_cancel;
        i_req.wr && (i_req.addr == 16'hff80 || i_req.addr == 16'hff84)
            |=> !o_conversion_end_irq [*2];
    endproperty
    a_cancel: assert property (p_cancel) else $error("end pulse after cancel");
endmodule : adc_mode_control_regs_checker

bind adc_mode_control_regs adc_mode_control_regs_checker adc_mode_control_regs_checker_i (
    .i_clk, .i_rstn, .i_req, .o_mode, .o_clksel, .o_channel, .o_bandgap_on, .o_sample,
    .o_conversion_end_irq, .o_event);

// >>> adc_mode_control_regs_tb.sv
// testbench: register access and conversion timing of the converter control
`timescale 1ns/100ps
module adc_mode_control_regs_tb;
    localparam int div = 2;
    // 14 us of band-gap settling at 4 ns per cycle
    localparam int bg_wait = 3500;
    localparam int time_limit = 12000;
    logic i_clk, i_rstn, o_bandgap_on, o_sample, o_conversion_end_irq;
    logic i_subclk_x4 = 1'b0;
    logic sub_run;
    logic [7:0] i_sar_value, o_rdata, o_mode, o_clksel;
    logic [2:0] o_channel;
    adc_mode_pkg::reg_req_s i_req;
    adc_mode_pkg::conv_event_s o_event;
    int failures, cmp_count, n;
    int cycles = 0;
    adc_mode_control_regs #(.main_div(div)) adc_mode_control_regs_i (.i_clk, .i_rstn, .i_req,
        .i_subclk_x4, .i_sar_value, .o_rdata, .o_mode, .o_clksel, .o_channel, .o_bandgap_on,
        .o_sample, .o_conversion_end_irq, .o_event);
    initial begin
        i_clk = 0;
        forever #2 i_clk = ~i_clk;
    end
    // x4 subclock toggles every cycle only while the test wants it
    always @(negedge i_clk) if (sub_run) i_subclk_x4 <= ~i_subclk_x4;
    always @(negedge i_clk) cycles <= cycles + 1;
    task automatic chk(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic put(input logic [15:0] a, input logic [7:0] d, input logic b = 0,
                       input logic [2:0] k = 0);
        @(negedge i_clk);
        i_req = '{wr: 1'b1, rd: 1'b0, bit_op: b, bit_idx: k, addr: a, wdata: d};
        @(negedge i_clk);
        i_req = '0;
    endtask : put
    task automatic get(input logic [15:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        i_req = '{wr: 1'b0, rd: 1'b1, bit_op: 1'b0, bit_idx: 3'h0, addr: a, wdata: 8'h00};
        @(negedge i_clk);
        i_req = '0;
        chk("rdata", {8'h00, o_rdata}, {8'h00, exp});
    endtask : get
    task automatic wait_irq;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_conversion_end_irq !== 1'b1 && n < 2000);
    endtask : wait_irq
    task automatic t_access;
        get(16'hff80, 8'h00);
        get(16'hff81, 8'h00);
        get(16'hff84, 8'h00);
        // reserved mode bits written as zero
        put(16'hff80, 8'h21);
        get(16'hff80, 8'h21);
        put(16'hff80, 8'h00);
        put(16'hff80, 8'h01, 1'b1, 3'h0);
        get(16'hff80, 8'h01);
        chk("bandgap", 16'(o_bandgap_on), 16'h1);
        put(16'hff81, 8'hff);
        get(16'hff81, 8'h80);
        put(16'hff81, 8'h01, 1'b1, 3'h7);
        get(16'hff81, 8'h80);
        put(16'hff81, 8'h00);
        put(16'hff84, 8'h05);
        get(16'hff84, 8'h05);
        chk("channel", 16'(o_channel), 16'h5);
        put(16'hff84, 8'h01, 1'b1, 3'h1);
        get(16'hff84, 8'h07);
        get(16'hff90, 8'h00);
    endtask : t_access
    task automatic t_times;
        logic [7:0] per [4] = '{8'h90, 8'h78, 8'h60, 8'h48};
        logic [2:0] code [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        // band-gap settles before the first start
        put(16'hff80, 8'h01);
        repeat (bg_wait) @(negedge i_clk);
        for (int i = 0; i < 4; i++) begin
            i_sar_value = 8'h30 + 8'(i);
            put(16'hff80, 8'h81 | {2'b00, code[i], 3'b000});
            wait_irq();
            chk("first defined", 16'(o_event.first_undefined), 16'h0);
            wait_irq();
            chk("interval", 16'(n), 16'(per[i]) * 16'(div));
            chk("event result", 16'(o_event.result), 16'h30 + 16'(i));
            get(16'hff85, 8'h30 + 8'(i));
        end
    endtask : t_times
    task automatic t_cancel;
        put(16'hff80, 8'ha1);
        wait_irq();
        repeat (60) @(negedge i_clk);
        put(16'hff84, 8'h03);
        wait_irq();
        chk("restart", 16'(n > 100), 16'h1);
        put(16'hff80, 8'h01);
        repeat (2) @(negedge i_clk);
        chk("sample", 16'(o_sample), 16'h0);
    endtask : t_cancel
    task automatic t_sub;
        // x4 clock running before it is selected
        sub_run = 1;
        put(16'hff81, 8'h80);
        put(16'hff80, 8'h81);
        wait_irq();
        wait_irq();
        // 72 x4 edges, one every two cycles, whatever the time code
        chk("subclk", 16'(n), 16'(adc_mode_pkg::periods_100) * 16'd2);
        put(16'hff80, 8'h00);
        put(16'hff81, 8'h00);
        sub_run = 0;
    endtask : t_sub
    task automatic t_undef;
        put(16'hff80, 8'h80);
        wait_irq();
        chk("undefined", 16'(o_event.first_undefined), 16'h1);
        wait_irq();
        chk("second defined", 16'(o_event.first_undefined), 16'h0);
        put(16'hff80, 8'h00);
    endtask : t_undef
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    initial begin
        {i_rstn, sub_run, i_sar_value} = '0;
        i_req = '0;
        {failures, cmp_count} = '0;
        repeat (8) @(negedge i_clk);
        i_rstn = 1;
        fork
            begin
                t_access();
                t_times();
                t_cancel();
                t_sub();
                t_undef();
            end
            begin
                wait (cycles == time_limit);
                failures++;
            end
        join_any
        wrap_up();
    end
endmodule : adc_mode_control_regs_tb
